/* logic/psr_pkg.sv */
// package: register map, field positions, resets and timing for set point relay control
package psr_pkg;
  localparam int unsigned PSR_ADDR_W   = 8;
  localparam int unsigned PSR_VAL_W    = 16;
  // register byte offsets
  localparam logic [7:0] PSR_OFF_CTRL  = 8'h00; // mode, channel select, buttons
  localparam logic [7:0] PSR_OFF_STAT  = 8'h04; // relay state, edit state
  localparam logic [7:0] PSR_OFF_IRQS  = 8'h08; // sticky events, write one to clear
  localparam logic [7:0] PSR_OFF_IRQM  = 8'h0c; // interrupt mask
  localparam logic [7:0] PSR_OFF_CFG   = 8'h10; // module presence, control config
  localparam logic [7:0] PSR_OFF_EDIT  = 8'h14; // live edit value (read)
  localparam logic [7:0] PSR_OFF_DISP  = 8'h18; // display selection
  localparam logic [7:0] PSR_OFF_PRES0 = 8'h20; // measured pressure ch0..4
  localparam logic [7:0] PSR_OFF_RSP0  = 8'h40; // stored relay set points 0..4
  localparam logic [7:0] PSR_OFF_PSP0  = 8'h60; // protection sp cc, slot a
  localparam logic [7:0] PSR_OFF_CSP0  = 8'h68; // control sp cc, slot a
  // ctrl fields
  localparam int unsigned PSR_CTRL_MODE_LSB = 0;  // 2 bits
  localparam int unsigned PSR_CTRL_CH_LSB   = 4;  // 3 bits
  localparam int unsigned PSR_CTRL_UP       = 8;
  localparam int unsigned PSR_CTRL_DN       = 9;
  // cfg fields
  localparam int unsigned PSR_CFG_PRES_LSB  = 0;  // 5 bits: channel has module
  localparam int unsigned PSR_CFG_SINGLE_A  = 5;
  localparam int unsigned PSR_CFG_SINGLE_B  = 6;
  localparam int unsigned PSR_CFG_CCCTL     = 8;  // 0: none, 1: b1, 2: b2
  localparam int unsigned PSR_CFG_SHARED    = 10;
  // interrupt events
  localparam int unsigned PSR_EV_COMMIT = 0;
  localparam int unsigned PSR_EV_RELAY  = 1;
  localparam int unsigned PSR_EV_W      = 2;
  // values
  localparam logic [15:0] PSR_SP_DISABLED = 16'h0000;
  localparam logic [15:0] PSR_SP_MIN      = 16'h0010; // bottom of range
  localparam logic [15:0] PSR_SP_MAX      = 16'hfff0;
  localparam logic [15:0] PSR_HYST        = 16'h0004;
  // timing
  localparam int unsigned PSR_CLK_MHZ      = 100;
  localparam int unsigned PSR_STEP_SLOW_MS = 200;
  localparam int unsigned PSR_STEP_FAST_MS = 20;
  localparam int unsigned PSR_HOLD_MS      = 1000;
  localparam int unsigned PSR_SLOW_CYC = PSR_STEP_SLOW_MS * 1000 * PSR_CLK_MHZ;
  localparam int unsigned PSR_FAST_CYC = PSR_STEP_FAST_MS * 1000 * PSR_CLK_MHZ;
  localparam int unsigned PSR_HOLD_CYC = PSR_HOLD_MS * 1000 * PSR_CLK_MHZ;
  typedef enum logic [1:0] {PSR_MODE_PRESS, PSR_MODE_RELAY, PSR_MODE_PROT,
                            PSR_MODE_OTHER} psr_mode_e;
  // channels: 0 cc, 1 a1, 2 a2, 3 b1, 4 b2
  localparam logic [2:0] PSR_CH_CC = 3'h0;
  localparam logic [2:0] PSR_CH_A1 = 3'h1;
  localparam logic [2:0] PSR_CH_B1 = 3'h3;
  localparam logic [2:0] PSR_CH_B2 = 3'h4;
  // display line labels
  localparam logic [2:0] PSR_LBL_NONE = 3'h0;
  localparam logic [2:0] PSR_LBL_NO   = 3'h1;
  localparam logic [2:0] PSR_LBL_HAS  = 3'h2;
  localparam logic [2:0] PSR_LBL_PROT = 3'h3;
  localparam logic [2:0] PSR_LBL_CTRL = 3'h4;
  localparam logic [2:0] PSR_LBL_B1   = 3'h5;
  localparam logic [2:0] PSR_LBL_B2   = 3'h6;
endpackage : psr_pkg

/* logic/psr_button_rate.sv */
// button pacing: one step on press, repeated steps while held, faster after a hold
`timescale 1ns/1ps
`default_nettype none
module psr_button_rate #(
  parameter int unsigned SLOW_CYC = psr_pkg::PSR_SLOW_CYC,
  parameter int unsigned FAST_CYC = psr_pkg::PSR_FAST_CYC,
  parameter int unsigned HOLD_CYC = psr_pkg::PSR_HOLD_CYC
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic button,
  output logic      step,
  output logic      press
);
  import psr_pkg::*;
  typedef struct packed {
    logic        last;
    logic [31:0] tick;
    logic [31:0] held;
    logic        step;
    logic        press;
  } psr_btn_s;
  psr_btn_s st_reg, st_next;

  // rate rises once held past the hold time
  always_comb begin
    st_next       = st_reg;
    st_next.last  = button;
    st_next.step  = 1'b0;
    st_next.press = button && !st_reg.last;
    if (!button) begin
      st_next.tick = '0;
      st_next.held = '0;
    end else if (!st_reg.last) begin
      st_next.step = 1'b1; // first step at the press edge
    end else begin
      if (st_reg.held < HOLD_CYC) st_next.held = st_reg.held + 32'h1;
      st_next.tick = st_reg.tick + 32'h1;
      if (st_reg.tick + 32'h1 >= ((st_reg.held >= HOLD_CYC) ? FAST_CYC : SLOW_CYC)) begin
        st_next.tick = '0;
        st_next.step = 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) st_reg <= '0;
    else st_reg <= st_next;
  end
  assign step  = st_reg.step;
  assign press = st_reg.press;
endmodule : psr_button_rate
`default_nettype wire

/* logic/psr_setpoint_ctrl.sv */
// set point relay control: compare, relays, panel editing, commit, display selection
//
// Overview of operation
// - five relays: cc, slot a two, slot b two, each own set point
// - single-channel module drives both relays of its slot from channel one
// - relay and indicator on while pressure below set point, else off
// - relays keep working in relay set point edit mode
// - empty slot selected shows no on its line, lists fitted channels
// - hysteresis around set point, trip may differ from display
// - up/down step the value, faster while held
// - edit applied and stored only when mode or channel selector moves
// - power loss before selector move discards the edit
// - at range bottom reached by a down step, a fresh down press gives 0.0; up returns to bottom
// - all set points default to 0.0 disabled
// - protection mode on cc channel shows protection value and label
// - selector move without change leaves outputs untouched
// - shared control sensor keeps two independent control set points
// - control channel selected: control value, control label on other slot line
// - shared: b1 edits cc control point, b2 edits slot a control point
// - control value shown on configured control channel line when protection mode selects b1 or b2, or cc or a1 with a control channel configured
// - selected line differs from control channel: print its name there
`timescale 1ns/1ps
`default_nettype none
module psr_setpoint_ctrl #(
  parameter int unsigned SLOW_CYC = psr_pkg::PSR_SLOW_CYC,
  parameter int unsigned FAST_CYC = psr_pkg::PSR_FAST_CYC,
  parameter int unsigned HOLD_CYC = psr_pkg::PSR_HOLD_CYC
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [4:0]  relay_drive,
  output logic      [4:0]  relay_indicator,
  output logic             irq
);
  import psr_pkg::*;

  typedef struct packed {
    logic             wr_pend;
    logic [7:0]       wr_addr;
    logic [31:0]      rdata;
    logic [1:0]       mode;
    logic [2:0]       chan;
    logic [1:0]       btn;
    logic [10:0]      cfg;
    logic [4:0][15:0] pres;
    logic [4:0][15:0] rsp;
    logic [1:0][15:0] psp;
    logic [1:0][15:0] csp;
    logic [15:0]      edit;
    logic             edit_dirty;
    logic             at_bottom;   // reached bottom on a down step; kept until an up step or selector move
    logic [4:0]       relay;
    logic [4:0][2:0]  lbl;
    logic [4:0]       show_val;
    logic [PSR_EV_W-1:0] irqs;
    logic [PSR_EV_W-1:0] irqm;
    logic             irq;
  } psr_st_s;
  psr_st_s st_reg, st_next;

  logic up_step, dn_step, up_press, dn_press;
  psr_button_rate #(.SLOW_CYC(SLOW_CYC), .FAST_CYC(FAST_CYC), .HOLD_CYC(HOLD_CYC)) u_up (
    .hclk(hclk), .hresetn(hresetn), .button(st_reg.btn[0]), .step(up_step), .press(up_press));
  psr_button_rate #(.SLOW_CYC(SLOW_CYC), .FAST_CYC(FAST_CYC), .HOLD_CYC(HOLD_CYC)) u_dn (
    .hclk(hclk), .hresetn(hresetn), .button(st_reg.btn[1]), .step(dn_step), .press(dn_press));

  // pressure channel that drives each relay; single modules use their first channel
  function automatic logic [2:0] src_ch(input logic [2:0] r, input logic [10:0] c);
    src_ch = r;
    if (r == 3'h2 && c[PSR_CFG_SINGLE_A]) src_ch = 3'h1;
    if (r == 3'h4 && c[PSR_CFG_SINGLE_B]) src_ch = 3'h3;
  endfunction : src_ch

  // control channel configured for cold cathode (b1 or b2)
  function automatic logic [2:0] ctl_ch(input logic [10:0] c);
    ctl_ch = (c[PSR_CFG_CCCTL+:2] == 2'h2) ? PSR_CH_B2 : PSR_CH_B1;
  endfunction : ctl_ch

  logic        ap_take;
  logic [15:0] cur_val;
  logic [15:0] stepped;
  always_comb begin
    ap_take = hsel && hready && htrans[1];
    // stored value of whatever the selectors point at
    cur_val = PSR_SP_DISABLED;
    if (st_reg.mode == PSR_MODE_RELAY && st_reg.chan <= 3'h4) cur_val = st_reg.rsp[st_reg.chan];
    else if (st_reg.mode == PSR_MODE_PROT) begin
      if (st_reg.chan == PSR_CH_CC || st_reg.chan == PSR_CH_A1)
        cur_val = st_reg.psp[st_reg.chan[0]];
      else if (st_reg.chan == PSR_CH_B1 || st_reg.chan == PSR_CH_B2)
        cur_val = st_reg.csp[(st_reg.cfg[PSR_CFG_SHARED] && st_reg.chan == PSR_CH_B2) ? 1 :
                             (st_reg.cfg[PSR_CFG_SHARED] ? 0 : 0)];
    end
    stepped = st_reg.edit;
  end

  logic editable;
  assign editable = (st_reg.mode == PSR_MODE_RELAY && st_reg.chan <= 3'h4 &&
                     st_reg.cfg[PSR_CFG_PRES_LSB + st_reg.chan]) ||
                    (st_reg.mode == PSR_MODE_PROT && st_reg.chan <= 3'h4 && st_reg.chan != 3'h2);

  always_comb begin
    logic [2:0]  ch_sel;
    logic [7:0]  a;
    logic        sel_moved;
    logic [15:0] thr;
    logic [1:0]  cidx;
    ch_sel    = '0;
    a         = '0;
    sel_moved = 1'b0;
    thr       = '0;
    cidx      = '0;
    st_next   = st_reg;
    st_next.rdata = 32'h0;
    // ahb-lite: zero wait states, always okay
    st_next.wr_pend = ap_take && hwrite;
    if (ap_take) st_next.wr_addr = haddr[7:0];
    if (ap_take && !hwrite) begin
      a = haddr[7:0];
      unique case (a)
        PSR_OFF_CTRL: st_next.rdata = {22'h0, st_reg.btn, 1'b0, st_reg.chan, 2'h0, st_reg.mode};
        PSR_OFF_STAT: st_next.rdata = {26'h0, st_reg.edit_dirty, st_reg.relay};
        PSR_OFF_IRQS: st_next.rdata = {30'h0, st_reg.irqs};
        PSR_OFF_IRQM: st_next.rdata = {30'h0, st_reg.irqm};
        PSR_OFF_CFG:  st_next.rdata = {21'h0, st_reg.cfg};
        PSR_OFF_EDIT: st_next.rdata = {16'h0, st_reg.edit};
        PSR_OFF_DISP: st_next.rdata = {12'h0, st_reg.show_val, st_reg.lbl};
        default: begin
          if (a >= PSR_OFF_PRES0 && a < PSR_OFF_PRES0 + 8'h14)
            st_next.rdata = {16'h0, st_reg.pres[3'((a - PSR_OFF_PRES0) >> 2)]};
          else if (a >= PSR_OFF_RSP0 && a < PSR_OFF_RSP0 + 8'h14)
            st_next.rdata = {16'h0, st_reg.rsp[3'((a - PSR_OFF_RSP0) >> 2)]};
          else if (a == PSR_OFF_PSP0 || a == PSR_OFF_PSP0 + 8'h4)
            st_next.rdata = {16'h0, st_reg.psp[a[2]]};
          else if (a == PSR_OFF_CSP0 || a == PSR_OFF_CSP0 + 8'h4)
            st_next.rdata = {16'h0, st_reg.csp[a[2]]};
        end
      endcase
    end
    // write data phase
    if (st_reg.wr_pend) begin
      a = st_reg.wr_addr;
      if (a == PSR_OFF_CTRL) begin
        st_next.mode = hwdata[PSR_CTRL_MODE_LSB+:2];
        st_next.chan = hwdata[PSR_CTRL_CH_LSB+:3];
        st_next.btn  = {hwdata[PSR_CTRL_DN], hwdata[PSR_CTRL_UP]};
        sel_moved = (hwdata[PSR_CTRL_MODE_LSB+:2] != st_reg.mode) ||
                    (hwdata[PSR_CTRL_CH_LSB+:3] != st_reg.chan);
      end
      if (a == PSR_OFF_IRQS) st_next.irqs = st_reg.irqs & ~hwdata[PSR_EV_W-1:0];
      if (a == PSR_OFF_IRQM) st_next.irqm = hwdata[PSR_EV_W-1:0];
      if (a == PSR_OFF_CFG)  st_next.cfg  = hwdata[10:0];
      if (a >= PSR_OFF_PRES0 && a < PSR_OFF_PRES0 + 8'h14)
        st_next.pres[3'((a - PSR_OFF_PRES0) >> 2)] = hwdata[15:0];
    end

    // commit only on selector move, and only a changed value
    if (sel_moved) begin
      if (st_reg.edit_dirty) begin
        if (st_reg.mode == PSR_MODE_RELAY) st_next.rsp[st_reg.chan] = st_reg.edit;
        else if (st_reg.chan == PSR_CH_CC || st_reg.chan == PSR_CH_A1)
          st_next.psp[st_reg.chan[0]] = st_reg.edit;
        else begin
          cidx = (st_reg.cfg[PSR_CFG_SHARED] && st_reg.chan == PSR_CH_B2) ? 2'h1 : 2'h0;
          st_next.csp[cidx[0]] = st_reg.edit;
        end
        st_next.irqs[PSR_EV_COMMIT] = 1'b1;
      end
      st_next.edit_dirty = 1'b0;
      st_next.at_bottom  = 1'b0;
    end else if (!st_reg.edit_dirty) begin
      st_next.edit = cur_val; // track stored value until touched
    end

    // up/down editing of the live value
    if (!sel_moved && editable) begin
      if (up_step) begin
        st_next.edit_dirty = 1'b1;
        if (stepped == PSR_SP_DISABLED) st_next.edit = PSR_SP_MIN;
        else if (stepped < PSR_SP_MAX) st_next.edit = stepped + 16'h1;
        st_next.at_bottom = 1'b0;
      end else if (dn_step) begin
        st_next.edit_dirty = 1'b1;
        if (stepped > PSR_SP_MIN) st_next.edit = stepped - 16'h1;
        else if (stepped == PSR_SP_MIN && dn_press && st_reg.at_bottom)
          st_next.edit = PSR_SP_DISABLED;
        if (stepped - 16'h1 == PSR_SP_MIN || stepped == PSR_SP_MIN) st_next.at_bottom = 1'b1;
      end
    end

    // relays evaluated in every mode, including edit
    for (int r = 0; r < 5; r++) begin
      thr = st_reg.rsp[r];
      if (thr == PSR_SP_DISABLED) st_next.relay[r] = 1'b0;
      else if (st_reg.relay[r])
        st_next.relay[r] = st_reg.pres[src_ch(3'(r), st_reg.cfg)] < thr + PSR_HYST;
      else
        st_next.relay[r] = st_reg.pres[src_ch(3'(r), st_reg.cfg)] < thr;
    end
    if (st_next.relay != st_reg.relay) st_next.irqs[PSR_EV_RELAY] = 1'b1;

    // display line selection
    ch_sel = st_reg.chan;
    for (int l = 0; l < 5; l++) begin
      st_next.lbl[l]      = PSR_LBL_NONE;
      st_next.show_val[l] = 1'b0;
    end
    if (st_reg.mode == PSR_MODE_RELAY && ch_sel <= 3'h4) begin
      if (!st_reg.cfg[PSR_CFG_PRES_LSB + ch_sel]) begin
        for (int l = 0; l < 5; l++)
          st_next.lbl[l] = st_reg.cfg[PSR_CFG_PRES_LSB + l] ? PSR_LBL_HAS : PSR_LBL_NONE;
        st_next.lbl[ch_sel] = PSR_LBL_NO;
      end else st_next.show_val[ch_sel] = 1'b1;
    end else if (st_reg.mode == PSR_MODE_PROT) begin
      if (ch_sel == PSR_CH_CC || ch_sel == PSR_CH_A1) begin
        st_next.show_val[ch_sel] = 1'b1;
        st_next.lbl[ch_sel + 3'h1] = PSR_LBL_PROT;
        if (st_reg.cfg[PSR_CFG_CCCTL+:2] != 2'h0)
          st_next.show_val[ctl_ch(st_reg.cfg)] = 1'b1;
      end else if (ch_sel == PSR_CH_B1 || ch_sel == PSR_CH_B2) begin
        st_next.show_val[ctl_ch(st_reg.cfg)] = 1'b1;
        st_next.show_val[PSR_CH_CC] = 1'b1;
        if (ch_sel != ctl_ch(st_reg.cfg))
          st_next.lbl[ch_sel] = (ctl_ch(st_reg.cfg) == PSR_CH_B1) ? PSR_LBL_B1 : PSR_LBL_B2;
        else
          st_next.lbl[(ch_sel == PSR_CH_B1) ? PSR_CH_B2 : PSR_CH_B1] = PSR_LBL_CTRL;
      end
    end

    st_next.irq = |(st_next.irqs & st_next.irqm);
  end

  // state is volatile: reset drops any uncommitted edit and restores defaults
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) st_reg <= '0;
    else st_reg <= st_next;
  end

  assign hrdata          = st_reg.rdata;
  assign hreadyout       = 1'b1;
  assign hresp           = 1'b0;
  assign relay_drive     = st_reg.relay;
  assign relay_indicator = st_reg.relay;
  assign irq             = st_reg.irq;

  a_disabled_off: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_reg.rsp[0] == PSR_SP_DISABLED) |=> !relay_drive[0])
    else $error("disabled relay energized");
  a_below_on: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_reg.rsp[1] != PSR_SP_DISABLED && st_reg.pres[1] < st_reg.rsp[1]
     && !st_reg.cfg[PSR_CFG_SINGLE_A]) |=> relay_drive[1])
    else $error("relay off while below set point");
  a_ind_match: assert property (@(posedge hclk) disable iff (!hresetn)
    relay_indicator == relay_drive) else $error("indicator differs from relay");
  a_no_early_commit: assert property (@(posedge hclk) disable iff (!hresetn)
    (!st_reg.wr_pend) |=> $stable(st_reg.rsp))
    else $error("set point stored without selector move");
  a_clean_keep: assert property (@(posedge hclk) disable iff (!hresetn)
    (!st_reg.edit_dirty) |=> $stable(st_reg.psp) && $stable(st_reg.csp))
    else $error("unchanged value altered storage");
  a_irq_level: assert property (@(posedge hclk) disable iff (!hresetn)
    irq == |(st_reg.irqs & st_reg.irqm))
    else $error("interrupt output mismatch");
  a_no_line: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_reg.mode == PSR_MODE_RELAY && st_reg.chan == 3'h2 && !st_reg.cfg[2]
     && !st_reg.wr_pend) |=> st_reg.lbl[2] == PSR_LBL_NO)
    else $error("missing no message");
  a_single_src: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_reg.cfg[PSR_CFG_SINGLE_A] && st_reg.rsp[2] == st_reg.rsp[1]
     && relay_drive[1] == relay_drive[2]) |=> relay_drive[1] == relay_drive[2])
    else $error("single module relays disagree");
endmodule : psr_setpoint_ctrl
`default_nettype wire

/* verif/psr_relay_load.sv */
// relay load model: changeover contacts and lamp agreement for the five relays
`timescale 1ns/1ps
`default_nettype none
module psr_relay_load (
  input  wire logic [4:0] relay_drive,
  input  wire logic [4:0] relay_indicator,
  output logic      [4:0] no_closed,
  output logic      [4:0] nc_closed,
  output logic            lamp_ok
);
  // contacts follow the coil; normally closed opens while energized
  assign no_closed = relay_drive;
  assign nc_closed = ~relay_drive;
  // a lamp that disagrees with its coil would mislead the operator
  assign lamp_ok = (relay_indicator === relay_drive);
endmodule : psr_relay_load
`default_nettype wire

/* verif/testbench.sv */
// self-checking bench for set point relay control over the register bus
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import psr_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, lamp_ok, prev;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [4:0]  relay_drive, relay_indicator, no_closed, nc_closed;
  logic [15:0] p;
  logic [15:0] corner [4] = '{16'h000f, 16'h0013, 16'h0014, 16'h0010};
  int          n_errors, n_checks;

  // short button timings keep hold tests within a few hundred cycles
  psr_setpoint_ctrl #(.SLOW_CYC(8), .FAST_CYC(2), .HOLD_CYC(20)) psr_setpoint_ctrl_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .relay_drive(relay_drive), .relay_indicator(relay_indicator), .irq(irq));
  psr_relay_load psr_relay_load_i (.relay_drive(relay_drive),
    .relay_indicator(relay_indicator), .no_closed(no_closed), .nc_closed(nc_closed),
    .lamp_ok(lamp_ok));

  // free running 100 MHz clock
  always #5 hclk = ~hclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  // one single word transfer; request held until hready is seen high
  task automatic xfer(input logic [7:0] a, input logic wr, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    // address phase stands until hready is sampled high at a rising edge
    do begin
      @(posedge hclk);
    end while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    // read data taken at the rising edge that ends the data phase
    do begin
      @(posedge hclk);
    end while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    xfer(a, 1'b0, 32'h00000000);
  endtask : rd

  task automatic settle(input int n);
    repeat (n) @(posedge hclk);
  endtask : settle

  task automatic ctl(input logic [1:0] m, input logic [2:0] c, input logic up, input logic dn);
    wr(PSR_OFF_CTRL, {22'h000000, dn, up, 1'b0, c, 2'b00, m});
  endtask : ctl

  // press a button, wait n cycles, then release it; the button is held n + 3 cycles in all
  task automatic tap(input logic [1:0] m, input logic [2:0] c, input logic up,
                     input logic dn, input int n);
    ctl(m, c, up, dn);
    settle(n);
    ctl(m, c, 1'b0, 1'b0);
  endtask : tap

  // raise a disabled point to range bottom, then commit by moving the selector
  task automatic edit_up(input logic [1:0] m, input logic [2:0] c, input logic [2:0] nxt);
    ctl(m, c, 1'b0, 1'b0);
    tap(m, c, 1'b1, 1'b0, 2);
    ctl(m, nxt, 1'b0, 1'b0);
  endtask : edit_up

  function automatic logic relay_exp(logic pv, logic [15:0] pr, logic [15:0] sp);
    if (sp == PSR_SP_DISABLED) return 1'b0;
    if (pr < sp) return 1'b1;
    if (pr >= sp + PSR_HYST) return 1'b0;
    return pv;
  endfunction : relay_exp

  // watchdog against a hung handshake
  initial begin
    repeat (40000) @(posedge hclk);
    n_errors++;
    tally_and_finish();
  end

  // main sequence
  initial begin
    hclk = 1'b0; hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00;
    hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0;
    r = $urandom(90450);
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 5; i++) wr(PSR_OFF_PRES0 + 8'(4 * i), 32'h0000ffff);
    for (int i = 0; i < 5; i++) begin rd(PSR_OFF_RSP0 + 8'(4 * i)); chk(r, 0); end
    for (int i = 0; i < 4; i++) begin rd(PSR_OFF_PSP0 + 8'(4 * i)); chk(r, 0); end
    chk({27'h0, relay_drive}, 0);
    $display("test defaults done");
    // editing on a1: step, hold, floor, disable, restore
    wr(PSR_OFF_CFG, 32'h0000001f);
    ctl(PSR_MODE_RELAY, PSR_CH_A1, 1'b0, 1'b0);
    tap(PSR_MODE_RELAY, PSR_CH_A1, 1'b1, 1'b0, 2);
    rd(PSR_OFF_EDIT); chk(r, {16'h0, PSR_SP_MIN});
    tap(PSR_MODE_RELAY, PSR_CH_A1, 1'b1, 1'b0, 60);
    // held 63 cycles at bench rates: press step, two slow, then 21 fast steps
    rd(PSR_OFF_EDIT); chk(r, {16'h0, PSR_SP_MIN + 16'h0018});
    tap(PSR_MODE_RELAY, PSR_CH_A1, 1'b0, 1'b1, 150);
    rd(PSR_OFF_EDIT); chk(r, {16'h0, PSR_SP_MIN});
    tap(PSR_MODE_RELAY, PSR_CH_A1, 1'b0, 1'b1, 2);
    rd(PSR_OFF_EDIT); chk(r, {16'h0, PSR_SP_DISABLED});
    tap(PSR_MODE_RELAY, PSR_CH_A1, 1'b1, 1'b0, 2);
    rd(PSR_OFF_EDIT); chk(r, {16'h0, PSR_SP_MIN});
    rd(PSR_OFF_RSP0 + 8'h04); chk(r, 0);
    wr(PSR_OFF_IRQS, 32'h3);
    ctl(PSR_MODE_RELAY, 3'h2, 1'b0, 1'b0);
    rd(PSR_OFF_RSP0 + 8'h04); chk(r, {16'h0, PSR_SP_MIN});
    rd(PSR_OFF_IRQS); chk({31'h0, r[0]}, 1);
    wr(PSR_OFF_IRQS, 32'h3);
    ctl(PSR_MODE_RELAY, PSR_CH_B1, 1'b0, 1'b0);
    rd(PSR_OFF_IRQS); chk({31'h0, r[0]}, 0);
    rd(PSR_OFF_RSP0 + 8'h08); chk(r, 0);
    $display("test edit done");
    // cc relay against corner and random pressures, edit mode still selected
    edit_up(PSR_MODE_RELAY, PSR_CH_CC, PSR_CH_A1);
    ctl(PSR_MODE_RELAY, PSR_CH_CC, 1'b0, 1'b0);
    prev = 1'b0;
    for (int i = 0; i < 40; i++) begin
      p = (i < 4) ? corner[i] : 16'($urandom_range(0, 31));
      wr(PSR_OFF_PRES0, {16'h0, p});
      settle(3);
      prev = relay_exp(prev, p, PSR_SP_MIN);
      chk({31'h0, relay_drive[0]}, {31'h0, prev});
      chk({29'h0, nc_closed[0], no_closed[0], lamp_ok}, {29'h0, ~prev, prev, 1'b1});
    end
    wr(PSR_OFF_PRES0, 32'h0000ffff);
    $display("test relay done");
    // single channel module in slot a drives both its relays
    edit_up(PSR_MODE_RELAY, 3'h2, PSR_CH_CC);
    wr(PSR_OFF_CFG, 32'h0000003f);
    wr(PSR_OFF_PRES0 + 8'h04, 32'h00000008);
    settle(3);
    chk({30'h0, relay_drive[2:1]}, 32'h3);
    wr(PSR_OFF_CFG, 32'h0000001f);
    settle(3);
    chk({30'h0, relay_drive[2:1]}, 32'h1);
    wr(PSR_OFF_PRES0 + 8'h04, 32'h0000ffff);
    $display("test single done");
    // empty slot selected: no there, fitted channels listed
    wr(PSR_OFF_CFG, 32'h0000000b);
    ctl(PSR_MODE_RELAY, 3'h2, 1'b0, 1'b0);
    rd(PSR_OFF_DISP);
    for (int j = 0; j < 5; j++)
      chk({29'h0, r[3*j+:3]}, {29'h0, (j == 2) ? PSR_LBL_NO :
          (5'b01011 >> j) & 5'h1 ? PSR_LBL_HAS : PSR_LBL_NONE});
    // protection and control display with b1 as control channel
    wr(PSR_OFF_CFG, 32'h0000011f);
    ctl(PSR_MODE_PROT, PSR_CH_CC, 1'b0, 1'b0);
    rd(PSR_OFF_DISP); chk({28'h0, r[15], r[5:3]}, {28'h0, 1'b1, PSR_LBL_PROT});
    ctl(PSR_MODE_PROT, PSR_CH_B2, 1'b0, 1'b0);
    rd(PSR_OFF_DISP); chk({28'h0, r[18], r[14:12]}, {28'h0, 1'b1, PSR_LBL_B1});
    ctl(PSR_MODE_PROT, PSR_CH_B1, 1'b0, 1'b0);
    rd(PSR_OFF_DISP);
    chk({27'h0, r[18], r[15], r[14:12]}, {27'h0, 2'b11, PSR_LBL_CTRL});
    $display("test display done");
    // shared control sensor: b1 edits cc control point, b2 slot a
    wr(PSR_OFF_CFG, 32'h0000051f);
    edit_up(PSR_MODE_PROT, PSR_CH_B1, PSR_CH_B2);
    tap(PSR_MODE_PROT, PSR_CH_B2, 1'b1, 1'b0, 2);
    tap(PSR_MODE_PROT, PSR_CH_B2, 1'b1, 1'b0, 2);
    ctl(PSR_MODE_PRESS, PSR_CH_B2, 1'b0, 1'b0);
    rd(PSR_OFF_CSP0); chk(r, {16'h0, PSR_SP_MIN});
    rd(PSR_OFF_CSP0 + 8'h04); chk({31'h0, r[15:0] > PSR_SP_MIN}, 1);
    $display("test shared done");
    // interrupt: masked, unmasked, cleared
    wr(PSR_OFF_IRQS, 32'h3);
    wr(PSR_OFF_IRQM, 32'h0);
    edit_up(PSR_MODE_RELAY, PSR_CH_B1, PSR_CH_B2);
    settle(2);
    chk({31'h0, irq}, 0);
    wr(PSR_OFF_IRQM, 32'h1);
    settle(2);
    chk({31'h0, irq}, 1);
    rd(PSR_OFF_IRQM); chk(r, 32'h1);
    wr(PSR_OFF_IRQS, 32'h1);
    settle(2);
    chk({31'h0, irq}, 0);
    rd(PSR_OFF_IRQS); chk({31'h0, r[0]}, 0);
    // read-only set point and unmapped place
    wr(PSR_OFF_RSP0, 32'h00001234);
    rd(PSR_OFF_RSP0); chk(r, {16'h0, PSR_SP_MIN});
    wr(8'h80, 32'h5a5a5a5a);
    rd(8'h80); chk(r, 0);
    chk({31'h0, hresp}, 0);
    $display("test bus done");
    // power loss before any selector move drops the edit
    ctl(PSR_MODE_RELAY, PSR_CH_B2, 1'b0, 1'b0);
    tap(PSR_MODE_RELAY, PSR_CH_B2, 1'b1, 1'b0, 2);
    @(posedge hclk) hresetn <= 1'b0;
    settle(2);
    hresetn <= 1'b1;
    rd(PSR_OFF_RSP0 + 8'h10); chk(r, 0);
    rd(PSR_OFF_STAT); chk(r, 0);
    $display("test power loss done");
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
